// ### common/clk_ctrl_pkg.sv
// constants, register map and state types of the oscillator and sleep controller
package clk_ctrl_pkg;

	// ***********************************
	// clock and timing
	// ***********************************
	localparam int CLK_PERIOD_NS = 10;
	// least dead time between deselecting one source and selecting the other
	localparam int SW_GAP_NS = 30;
	localparam int SW_GAP_CYC = (SW_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// least start-up time granted to an oscillator leaving power-down
	localparam int OSC_START_NS = 20000;
	localparam int OSC_START_CYC = (OSC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ***********************************
	// register offsets (byte addresses)
	// ***********************************
	localparam int ADR_W = 8;
	localparam logic [7:0] OFS_PWR = 8'h00;
	localparam logic [7:0] OFS_SEL = 8'h04;
	localparam logic [7:0] OFS_OSC = 8'h08;
	localparam logic [7:0] OFS_STAT = 8'h0c;

	// ***********************************
	// field positions
	// ***********************************
	localparam int PWR_SLEEP_BIT = 0;
	localparam int PWR_DEEP_BIT = 1;
	localparam int SEL_SRC_BIT = 0;
	localparam int OSC_MAIN_BIT = 0;
	localparam int OSC_LOW_BIT = 1;
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_SEL_MAIN_BIT = 2;
	localparam int STAT_SEL_LOW_BIT = 3;
	localparam int STAT_BUSY_BIT = 4;

	// ***********************************
	// reset values
	// ***********************************
	localparam logic RST_MAIN_EN = 1'b1;
	localparam logic RST_LOW_EN = 1'b0;
	localparam logic RST_SRC_SEL = 1'b1;
	localparam logic RST_FLAG = 1'b0;

	// ***********************************
	// state types
	// ***********************************
	typedef enum logic [1:0] {
		ST_RUN = 2'h0,
		ST_PDOWN = 2'h1,
		ST_WAKE = 2'h3,
		ST_IDLE = 2'h2
	} pm_state_t;

	typedef enum logic {
		SW_STEADY = 1'h0,
		SW_GAP = 1'h1
	} sw_state_t;

endpackage : clk_ctrl_pkg

// ### common/clk_sw_if.sv
// link between the power controller and the clock switch sequencer
`timescale 1ns/1ns
interface clk_sw_if;
	logic ce;
	logic src_req;
	logic osc_ready;
	logic sel_main;
	logic sel_low;
	logic busy;

	modport ctrl (output ce, output src_req, output osc_ready, input sel_main, input sel_low, input busy);
	modport seq (input ce, input src_req, input osc_ready, output sel_main, output sel_low, output busy);
endinterface : clk_sw_if

// ### hdl/clk_switch_seq.sv
// break-before-make sequencer for the two clock mux selects
`timescale 1ns/1ns
module clk_switch_seq
	import clk_ctrl_pkg::*;
#(
	parameter int GAP_CYC = SW_GAP_CYC
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// controller side
	clk_sw_if.seq sw
);

	sw_state_t state_ff;
	sw_state_t nxt_state;
	logic [7:0] gap_ff;
	logic [7:0] nxt_gap;
	logic cur_ff;
	logic nxt_cur;
	logic sel_main_ff;
	logic nxt_sel_main;
	logic sel_low_ff;
	logic nxt_sel_low;

	// ***********************************
	// next state
	// ***********************************
	// both selects stay low for the gap so no shortened clock phase reaches the core
	always_comb begin
		nxt_state = state_ff;
		nxt_gap = gap_ff;
		nxt_cur = cur_ff;
		nxt_sel_main = sel_main_ff;
		nxt_sel_low = sel_low_ff;
		case (state_ff)
			SW_STEADY: begin
				if ((sw.src_req != cur_ff) && sw.osc_ready) begin
					nxt_sel_main = 1'b0;
					nxt_sel_low = 1'b0;
					nxt_gap = 8'h00;
					nxt_state = SW_GAP;
				end
			end
			SW_GAP: begin
				nxt_gap = gap_ff + 8'h01;
				if (gap_ff == 8'(GAP_CYC - 1)) begin
					nxt_cur = sw.src_req;
					nxt_sel_main = sw.src_req;
					nxt_sel_low = ~sw.src_req;
					nxt_state = SW_STEADY;
				end
			end
			default: begin
				nxt_state = SW_STEADY;
			end
		endcase
	end

	// ***********************************
	// registers
	// ***********************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_ff <= SW_STEADY;
			gap_ff <= 8'h00;
			cur_ff <= RST_SRC_SEL;
			sel_main_ff <= RST_SRC_SEL;
			sel_low_ff <= ~RST_SRC_SEL;
		end else if (sw.ce) begin
			state_ff <= nxt_state;
			gap_ff <= nxt_gap;
			cur_ff <= nxt_cur;
			sel_main_ff <= nxt_sel_main;
			sel_low_ff <= nxt_sel_low;
		end
	end

	assign sw.sel_main = sel_main_ff;
	assign sw.sel_low = sel_low_ff;
	assign sw.busy = (state_ff == SW_GAP);

endmodule : clk_switch_seq

// ### hdl/dual_osc_idle_powerdown_ctrl.sv
// oscillator choice, idle and power-down controller with a wishbone register slave
//
// Implementation choices: the address map and register access over Wishbone.
`timescale 1ns/1ns
module dual_osc_idle_powerdown_ctrl
	import clk_ctrl_pkg::*;
#(
	parameter int OSC_START_CYCLES = OSC_START_CYC,
	parameter int GAP_CYCLES = SW_GAP_CYC
) (
	// clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// wake-up sources
	input wire logic irq_pending_i,
	input wire logic ext_irq_zero_n_i,
	input wire logic ext_irq_one_n_i,
	input wire logic ext_irq_zero_en_i,
	input wire logic ext_irq_one_en_i,
	input wire logic kbd_irq_i,
	input wire logic kbd_irq_en_i,
	// fuse bit: 1 restarts on main source, 0 on low-speed source
	input wire logic restart_clock_choice_i,
	// oscillator and clock mux control
	output logic main_osc_run_o,
	output logic low_osc_run_o,
	output logic sel_main_clk_o,
	output logic sel_low_clk_o,
	// power state
	output logic cpu_idle_o,
	output logic power_down_o
);

	// ***********************************
	// decode helper
	// ***********************************
	function automatic logic hit(input logic [ADR_W-1:0] adr, input logic [7:0] ofs);
		hit = (adr == ofs);
	endfunction : hit

	clk_sw_if sw ();

	// bus state
	logic ack_ff;
	logic nxt_ack;
	logic [31:0] rdat_ff;
	logic [31:0] nxt_rdat;
	logic bus_req;
	logic wr_lo;

	// control state
	pm_state_t state_ff;
	pm_state_t nxt_state;
	logic sleep_flag_ff;
	logic nxt_sleep_flag;
	logic deep_flag_ff;
	logic nxt_deep_flag;
	logic main_en_ff;
	logic nxt_main_en;
	logic low_en_ff;
	logic nxt_low_en;
	logic src_sel_ff;
	logic nxt_src_sel;
	logic [15:0] start_ff;
	logic [15:0] nxt_start;
	logic by_ext_ff;
	logic nxt_by_ext;
	logic main_run_ff;
	logic nxt_main_run;
	logic low_run_ff;
	logic nxt_low_run;
	logic idle_ff;
	logic nxt_idle;
	logic pdown_ff;
	logic nxt_pdown;

	// wake conditions
	logic ext_wake;
	logic kbd_wake;

	// register decode, shared by the read mux and the write path
	logic hit_pwr;
	logic hit_sel;
	logic hit_osc;
	logic hit_stat;

	// a request is taken only while ack is low, so each bus cycle acts once
	assign bus_req = wb_cyc_i && wb_stb_i && !ack_ff;
	assign wr_lo = bus_req && wb_we_i && wb_sel_i[0];
	assign hit_pwr = hit(wb_adr_i, OFS_PWR);
	assign hit_sel = hit(wb_adr_i, OFS_SEL);
	assign hit_osc = hit(wb_adr_i, OFS_OSC);
	assign hit_stat = hit(wb_adr_i, OFS_STAT);
	// external pins are active low; each external and keyboard source wakes the core only through its own enable
	assign ext_wake = (ext_irq_zero_en_i && !ext_irq_zero_n_i) || (ext_irq_one_en_i && !ext_irq_one_n_i);
	assign kbd_wake = kbd_irq_en_i && kbd_irq_i;

	// ***********************************
	// wishbone answer
	// ***********************************
	// one wait state; unmapped offsets are acked and read as zero
	always_comb begin
		nxt_ack = bus_req;
		nxt_rdat = 32'h0000_0000;
		if (bus_req && !wb_we_i) begin
			if (hit_pwr) begin
				nxt_rdat[PWR_SLEEP_BIT] = sleep_flag_ff;
				nxt_rdat[PWR_DEEP_BIT] = deep_flag_ff;
			end else if (hit_sel) begin
				nxt_rdat[SEL_SRC_BIT] = src_sel_ff;
			end else if (hit_osc) begin
				nxt_rdat[OSC_MAIN_BIT] = main_en_ff;
				nxt_rdat[OSC_LOW_BIT] = low_en_ff;
			end else if (hit_stat) begin
				nxt_rdat[STAT_STATE_LSB +: 2] = state_ff;
				nxt_rdat[STAT_SEL_MAIN_BIT] = sw.sel_main;
				nxt_rdat[STAT_SEL_LOW_BIT] = sw.sel_low;
				nxt_rdat[STAT_BUSY_BIT] = sw.busy;
			end
		end else if (!bus_req) begin
			nxt_rdat = rdat_ff;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff <= 1'b0;
			rdat_ff <= 32'h0000_0000;
		end else if (ce_i) begin
			ack_ff <= nxt_ack;
			rdat_ff <= nxt_rdat;
		end
	end

	// ***********************************
	// power state machine and control bits
	// ***********************************
	always_comb begin
		nxt_state = state_ff;
		nxt_sleep_flag = sleep_flag_ff;
		nxt_deep_flag = deep_flag_ff;
		nxt_main_en = main_en_ff;
		nxt_low_en = low_en_ff;
		nxt_src_sel = src_sel_ff;
		nxt_start = start_ff;
		nxt_by_ext = by_ext_ff;
		// source select and enables follow software; software keeps them legal
		if (wr_lo && hit_sel) begin
			nxt_src_sel = wb_dat_i[SEL_SRC_BIT];
		end
		if (wr_lo && hit_osc) begin
			nxt_main_en = wb_dat_i[OSC_MAIN_BIT];
			nxt_low_en = wb_dat_i[OSC_LOW_BIT];
		end
		case (state_ff)
			ST_RUN: begin
				if (wr_lo && hit_pwr) begin
					// deep sleep wins when both bits are written together
					if (wb_dat_i[PWR_DEEP_BIT]) begin
						nxt_deep_flag = 1'b1;
						nxt_state = ST_PDOWN;
					end else if (wb_dat_i[PWR_SLEEP_BIT]) begin
						nxt_sleep_flag = 1'b1;
						nxt_state = ST_IDLE;
					end
				end
			end
			ST_IDLE: begin
				// selects and enables untouched on the way out
				if (irq_pending_i || ext_wake || kbd_wake) begin
					nxt_sleep_flag = 1'b0;
					nxt_state = ST_RUN;
				end
			end
			ST_PDOWN: begin
				nxt_start = 16'h0000;
				if (kbd_wake) begin
					nxt_deep_flag = 1'b0;
					nxt_by_ext = 1'b0;
					nxt_state = ST_WAKE;
				end else if (ext_wake) begin
					nxt_by_ext = 1'b1;
					nxt_state = ST_WAKE;
				end
			end
			ST_WAKE: begin
				// power-down zeroes the count, so every wake attempt gets the full start-up time
				nxt_start = start_ff + 16'h0001;
				if (by_ext_ff && !ext_wake) begin
					// pin let go before the oscillator was up: sleep again
					nxt_state = ST_PDOWN;
				end else if (start_ff == 16'(OSC_START_CYCLES - 1)) begin
					nxt_deep_flag = 1'b0;
					nxt_state = ST_RUN;
				end
			end
			default: begin
				nxt_state = ST_RUN;
			end
		endcase
	end

	// oscillators run per their enables except in power-down; the enables restart the entry choice
	always_comb begin
		nxt_main_run = nxt_main_en && (nxt_state != ST_PDOWN);
		nxt_low_run = nxt_low_en && (nxt_state != ST_PDOWN);
		nxt_idle = (nxt_state == ST_IDLE);
		nxt_pdown = (nxt_state == ST_PDOWN) || (nxt_state == ST_WAKE);
	end

	// reset is synchronous, so the fuse bit may be taken here
	// main enable always resets high: the core keeps a running source while the
	// switch onto a low-speed fuse choice completes after release
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_ff <= ST_RUN;
			sleep_flag_ff <= RST_FLAG;
			deep_flag_ff <= RST_FLAG;
			main_en_ff <= RST_MAIN_EN;
			low_en_ff <= !restart_clock_choice_i;
			src_sel_ff <= restart_clock_choice_i;
			start_ff <= 16'h0000;
			by_ext_ff <= 1'b0;
			main_run_ff <= RST_MAIN_EN;
			low_run_ff <= RST_LOW_EN;
			idle_ff <= 1'b0;
			pdown_ff <= 1'b0;
		end else if (ce_i) begin
			state_ff <= nxt_state;
			sleep_flag_ff <= nxt_sleep_flag;
			deep_flag_ff <= nxt_deep_flag;
			main_en_ff <= nxt_main_en;
			low_en_ff <= nxt_low_en;
			src_sel_ff <= nxt_src_sel;
			start_ff <= nxt_start;
			by_ext_ff <= nxt_by_ext;
			main_run_ff <= nxt_main_run;
			low_run_ff <= nxt_low_run;
			idle_ff <= nxt_idle;
			pdown_ff <= nxt_pdown;
		end
	end

	// ***********************************
	// clock switch sequencer
	// ***********************************
	// switch only onto a running oscillator and never during power-down or wake
	// the old select is kept meanwhile, so the core never runs from a stopped source
	// a low clock enable freezes the sequencer along with the controller
	assign sw.ce = ce_i;
	assign sw.src_req = src_sel_ff;
	assign sw.osc_ready = (src_sel_ff ? main_run_ff : low_run_ff) && (state_ff != ST_PDOWN) && (state_ff != ST_WAKE);

	clk_switch_seq #(
		.GAP_CYC(GAP_CYCLES)
	) u_seq (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.sw(sw.seq)
	);

	// ***********************************
	// outputs
	// ***********************************
	// every output is a flip-flop, here or in the sequencer
	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdat_ff;
	assign main_osc_run_o = main_run_ff;
	assign low_osc_run_o = low_run_ff;
	assign sel_main_clk_o = sw.sel_main;
	assign sel_low_clk_o = sw.sel_low;
	assign cpu_idle_o = idle_ff;
	assign power_down_o = pdown_ff;

endmodule : dual_osc_idle_powerdown_ctrl

// ### verification/dual_osc_idle_powerdown_ctrl_checker.sv
// port assertions of the oscillator and sleep controller
`timescale 1ns/1ns
module dual_osc_idle_powerdown_ctrl_checker
	import clk_ctrl_pkg::*;
(
	// clock, reset, bus
	input wire logic clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	// wake sources and outputs
	input wire logic irq_pending_i, ext_irq_zero_n_i, ext_irq_zero_en_i, kbd_irq_i, kbd_irq_en_i,
	input wire logic restart_clock_choice_i, main_osc_run_o, low_osc_run_o,
	input wire logic sel_main_clk_o, sel_low_clk_o, cpu_idle_o, power_down_o
);
	// ********
	// assertions
	// ********
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// power register write accepted while running
	wire pwr_wr = wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i && wb_we_i && wb_adr_i == OFS_PWR
		&& wb_sel_i[0] && !cpu_idle_o && !power_down_o;
	wire asleep = power_down_o && !main_osc_run_o && !low_osc_run_o;
	wire kbd_wake = kbd_irq_i && kbd_irq_en_i;
	chk_reset_mode_a: assert property ($fell(rst_i) |-> main_osc_run_o && !low_osc_run_o
		&& sel_main_clk_o && !sel_low_clk_o && !cpu_idle_o && !power_down_o) else $error("bad reset state");
	chk_fuse_restart: assert property ($fell(rst_i) && !restart_clock_choice_i |=> low_osc_run_o)
		else $error("fuse choice ignored");
	chk_idle_entry: assert property (pwr_wr && wb_dat_i[1:0] == 2'h1 |=> cpu_idle_o)
		else $error("idle not entered");
	chk_idle_exit: assert property (cpu_idle_o && irq_pending_i && ce_i |-> ##[1:2] !cpu_idle_o)
		else $error("idle not left");
	chk_pdown_entry: assert property (pwr_wr && wb_dat_i[1] |=> asleep)
		else $error("power-down not entered");
	chk_pdown_hold: assert property (asleep && !kbd_wake && (ext_irq_zero_n_i || !ext_irq_zero_en_i)
		|=> power_down_o) else $error("power-down left early");
	chk_kbd_restart: assert property (asleep && kbd_wake && ce_i |=> main_osc_run_o || low_osc_run_o)
		else $error("keyboard wake failed");
	chk_sel_exclusive: assert property (!(sel_main_clk_o && sel_low_clk_o))
		else $error("both selects high");
	chk_switch_gap: assert property ($fell(sel_main_clk_o) || $fell(sel_low_clk_o)
		|-> (!sel_main_clk_o && !sel_low_clk_o) [*3]) else $error("switch gap short");
	cover property ($rose(cpu_idle_o));
	cover property ($rose(power_down_o));
	cover property ($fell(sel_main_clk_o));
endmodule : dual_osc_idle_powerdown_ctrl_checker
bind dual_osc_idle_powerdown_ctrl dual_osc_idle_powerdown_ctrl_checker chk_i (.clk_i, .rst_i, .ce_i,
	.wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o, .wb_adr_i, .wb_sel_i, .wb_dat_i, .irq_pending_i,
	.ext_irq_zero_n_i, .ext_irq_zero_en_i, .kbd_irq_i, .kbd_irq_en_i, .restart_clock_choice_i,
	.main_osc_run_o, .low_osc_run_o, .sel_main_clk_o, .sel_low_clk_o, .cpu_idle_o, .power_down_o);

// ### verification/dual_osc_idle_powerdown_ctrl_tb.sv
// self-checking bench of the oscillator and sleep controller
`timescale 1ns/1ns
module dual_osc_idle_powerdown_ctrl_tb;
	import clk_ctrl_pkg::*;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, irq = 1'b0, fuse = 1'b1;
	logic ext_req = 1'b0, kbd_req = 1'b0, s = 1'b1, ce = 1'b1, kbd_en = 1'b1;
	logic [7:0] adr = 8'h00, hold = 8'h00;
	logic [3:0] sel = 4'h1;
	logic [31:0] dat = 32'h0, q, rdat, rnd = 32'h59274913;
	logic [1:0] en = 2'h1;
	logic xz_n, xo_n, kb, ack, m_run, l_run, s_main, s_low, idle, pd;
	int n_mismatch = 0, comparisons = 0, cycles = 0;
	always #5 clk_i = ~clk_i;
	wake_src_model wake_src_model_i (.clk_i, .ext_req_i(ext_req), .kbd_req_i(kbd_req), .hold_i(hold),
		.ext_irq_zero_n_o(xz_n), .ext_irq_one_n_o(xo_n), .kbd_irq_o(kb));
	dual_osc_idle_powerdown_ctrl #(.OSC_START_CYCLES(8)) dual_osc_idle_powerdown_ctrl_i (.clk_i, .rst_i,
		.ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_pending_i(irq), .ext_irq_zero_n_i(xz_n),
		.ext_irq_one_n_i(xo_n), .ext_irq_zero_en_i(1'b1), .ext_irq_one_en_i(1'b1), .kbd_irq_i(kb),
		.kbd_irq_en_i(kbd_en), .restart_clock_choice_i(fuse), .main_osc_run_o(m_run), .low_osc_run_o(l_run),
		.sel_main_clk_o(s_main), .sel_low_clk_o(s_low), .cpu_idle_o(idle), .power_down_o(pd));
	// ********
	// helpers
	// ********
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr
	// the power and oscillator registers read back only their two low data bits, the select register only bit 0
	function automatic logic [31:0] low2(input logic [1:0] v);
		return {30'h0, v};
	endfunction : low2
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask : tick
	// classic cycle held until ack, released for one cycle after
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= rnd[3:0] | 4'h1;
		do @(posedge clk_i); while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		@(posedge clk_i);
	endtask : wb
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0);
		chk(q, exp);
	endtask : rd
	task automatic report_and_stop;
		$display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : report_and_stop
	// hang guard
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_mismatch++;
			report_and_stop();
		end
	end
	// ********
	// tests
	// ********
	initial begin
		tick(2);
		rst_i <= 1'b0;
		tick(1);
		rd(OFS_PWR, 32'h0);
		rd(OFS_SEL, 32'h1);
		rd(OFS_OSC, 32'h1);
		rd(OFS_STAT, 32'h4);
		wb(1'b1, 8'h10, rnd);
		rd(8'h10, 32'h0);
		$display("defaults done");
		repeat (6) begin
			rnd = lfsr(rnd);
			s = rnd[0];
			en = rnd[2:1] | (s ? 2'h1 : 2'h2);
			wb(1'b1, OFS_OSC, {rnd[31:2], 2'h3});
			wb(1'b1, OFS_SEL, {rnd[31:1], s});
			tick(6);
			chk({s_main, s_low}, {s, !s});
			wb(1'b1, OFS_OSC, {rnd[31:2], en});
			tick(2);
			chk({m_run, l_run}, {en[0], en[1]});
			rd(OFS_OSC, low2(en));
			rd(OFS_SEL, low2({1'b0, s}));
		end
		$display("source switching done");
		wb(1'b1, OFS_PWR, 32'h1);
		tick(1);
		chk(idle, 1'b1);
		rd(OFS_STAT, {27'h0, !s, s, 2'h2});
		rd(OFS_PWR, 32'h1);
		// a low clock enable holds idle although the interrupt is already up
		ce <= 1'b0;
		irq <= 1'b1;
		tick(3);
		chk(idle, 1'b1);
		ce <= 1'b1;
		tick(1);
		irq <= 1'b0;
		tick(3);
		chk(idle, 1'b0);
		rd(OFS_PWR, 32'h0);
		rd(OFS_SEL, low2({1'b0, s}));
		rd(OFS_OSC, low2(en));
		$display("idle done");
		wb(1'b1, OFS_PWR, 32'h3);
		chk({pd, m_run, l_run}, 3'h4);
		// a plain interrupt and a masked keyboard source must not end power-down
		irq <= 1'b1;
		kbd_en <= 1'b0;
		kbd_req <= 1'b1;
		tick(2);
		kbd_req <= 1'b0;
		tick(2);
		irq <= 1'b0;
		kbd_en <= 1'b1;
		chk({pd, m_run, l_run}, 3'h4);
		kbd_req <= 1'b1;
		tick(1);
		kbd_req <= 1'b0;
		tick(3);
		chk({m_run, l_run}, {en[0], en[1]});
		rd(OFS_PWR, 32'h0);
		tick(12);
		chk(pd, 1'b0);
		$display("keyboard wake done");
		wb(1'b1, OFS_PWR, 32'h2);
		hold <= 8'h03;
		ext_req <= 1'b1;
		tick(1);
		ext_req <= 1'b0;
		tick(10);
		chk({pd, m_run, l_run}, 3'h4);
		hold <= 8'h28;
		ext_req <= 1'b1;
		tick(1);
		ext_req <= 1'b0;
		tick(20);
		chk({pd, m_run, l_run}, {1'b0, en[0], en[1]});
		rd(OFS_PWR, 32'h0);
		$display("external wake done");
		fuse <= 1'b0;
		rst_i <= 1'b1;
		tick(2);
		rst_i <= 1'b0;
		tick(10);
		chk({s_main, s_low, m_run, l_run}, 4'h7);
		rd(OFS_SEL, 32'h0);
		rd(OFS_OSC, 32'h3);
		$display("fuse reset done");
		report_and_stop();
	end
endmodule : dual_osc_idle_powerdown_ctrl_tb

// ### verification/wake_src_model.sv
// far-side model of the external wake pins and the keyboard source
`timescale 1ns/1ns
module wake_src_model (
	// clock and bench requests
	input wire logic clk_i,
	input wire logic ext_req_i,
	input wire logic kbd_req_i,
	input wire logic [7:0] hold_i,
	// wake pins
	output logic ext_irq_zero_n_o,
	output logic ext_irq_one_n_o,
	output logic kbd_irq_o = 1'b0
);
	logic [7:0] cnt_ff = 8'h00;
	// pin pulled low for the asked count, then back to its pull-up
	always @(posedge clk_i) begin
		cnt_ff <= ext_req_i ? hold_i : cnt_ff - {7'h00, cnt_ff != 8'h00};
		kbd_irq_o <= kbd_req_i;
	end
	assign ext_irq_zero_n_o = (cnt_ff == 8'h00);
	assign ext_irq_one_n_o = 1'b1; // unused pin rests at pull-up level
endmodule : wake_src_model
